// ### rtl/dtcc_pkg.sv
// constants and types for the dual time-base capture/compare unit
// Summary of operation
// - sixteen channels, resolution one system clock in normal operation
// - staggered operation coarsens channel resolution to one step per eight clocks
// - two 16-bit timers, each with its own reload register
// - timer clock from prescaled system clock or upstream timer overflow events
// - timer may also advance from an external count input
// - sixteen channel registers, each assignable to either timer, capture or compare
// - each channel owns one pin: capture trigger input or compare output
// - capture copies assigned timer value into channel register on selected pin event
// - every capture raises the channel's own interrupt request
// - capture trigger selectable as rising, falling or either edge
// - compare-mode channels are matched against their assigned timer at each step of that timer
// - on equality the channel performs its selected compare mode action
// - compare mode 0 raises interrupt only; several matches per period allowed
// - compare mode 1 toggles the pin on every match
package dtcc_pkg;
   localparam int NUM_CH = 16;
   localparam int TW = 16;
   localparam int AW = 4;
   localparam int STAGGER_STEP = 8;
   // register word offsets (byte address = 4 * index)
   localparam logic [AW-1:0] IDX_T0_CNT = 4'h0;
   localparam logic [AW-1:0] IDX_T1_CNT = 4'h1;
   localparam logic [AW-1:0] IDX_T0_REL = 4'h2;
   localparam logic [AW-1:0] IDX_T1_REL = 4'h3;
   localparam logic [AW-1:0] IDX_TCTL = 4'h4;
   localparam logic [AW-1:0] IDX_CH_SEL = 4'h5;
   localparam logic [AW-1:0] IDX_CH_CFG = 4'h6;
   localparam logic [AW-1:0] IDX_CH_VAL = 4'h7;
   localparam logic [AW-1:0] IDX_IRQ = 4'h8;
   localparam logic [AW-1:0] IDX_PINS = 4'h9;
   // timer control fields, per timer 8 bits: [7]run [6:4]src [2:0]prescale
   localparam int TC_RUN = 7;
   localparam int TC_SRC_LSB = 4;
   localparam int TC_PRE_LSB = 0;
   localparam int TC_STAG = 16;
   // channel config fields: [0]timer [3:1]mode [5:4]edge [6]capture
   localparam int CF_TMR = 0;
   localparam int CF_MODE_LSB = 1;
   localparam int CF_EDGE_LSB = 4;
   localparam int CF_CAP = 6;
   localparam logic [2:0] SRC_PRE = 3'h0;
   localparam logic [2:0] SRC_UP = 3'h1;
   localparam logic [2:0] SRC_EXT = 3'h2;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [2:0] MODE_IRQ = 3'h0;
   localparam logic [2:0] MODE_TOGGLE = 3'h1;
   localparam logic [TW-1:0] TIMER_RST = 16'h0000;
   localparam logic [6:0] CFG_RST = 7'h00;
   typedef enum logic [1:0] {bus_idle_t_s, bus_ack_s} bus_state_t;
endpackage

// ### rtl/dtcc_unit.sv
// dual time-base sixteen-channel capture/compare unit with avalon slave
`timescale 1ns/1ns
`default_nettype none
module dual_timebase_cc_unit import dtcc_pkg::*; (
   // clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // avalon-mm slave, word addressed
   input wire logic [AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // count sources
   input wire logic upstream_gp_timer_ovf,
   input wire logic [1:0] ext_count_in,
   // channel pins
   input wire logic [NUM_CH-1:0] ch_pin_in,
   output logic [NUM_CH-1:0] ch_pin_out,
   output logic [NUM_CH-1:0] ch_pin_oe_n,
   // per-channel interrupt requests
   output logic [NUM_CH-1:0] ch_irq
);
   logic [TW-1:0] tmr_r [2];
   logic [TW-1:0] rel_r [2];
   logic [7:0] tctl_r [2];
   logic stag_r;
   logic [2:0] stag_cnt_r;
   logic [11:0] pre_r;
   logic ext_d_r [2];
   logic up_d_r;
   logic [AW-1:0] sel_r;
   logic [6:0] cfg_r [NUM_CH];
   logic [TW-1:0] val_r [NUM_CH];
   logic [NUM_CH-1:0] pin_d_r;
   logic [NUM_CH-1:0] pin_out_r;
   logic [NUM_CH-1:0] irq_r;
   logic [31:0] rdata_r;
   logic wait_r;
   bus_state_t bst_r;
   logic [TW-1:0] tmr_at_tick [2];
   logic tick [2];
   logic wr_acc, rd_acc;
   logic [NUM_CH-1:0] cap_ev, cmp_ev;
   logic [31:0] rd_mux;

   // timer word of a channel, selected by its assignment bit
   function automatic logic [TW-1:0] ch_timer(input logic t, input logic [TW-1:0] a, input logic [TW-1:0] b);
      ch_timer = t ? b : a;
   endfunction

   // requests are taken in the idle state; a write lands where waitrequest is seen low
   assign wr_acc = clk_en && avs_write && bst_r == bus_ack_s;
   assign rd_acc = clk_en && avs_read && bst_r == bus_idle_t_s;
   // staggered mode gates all time bases to one step in eight
   wire stag_ok = !stag_r || stag_cnt_r == 3'(STAGGER_STEP - 1);

   // count-source selection per timer
   generate
      for (genvar t = 0; t < 2; t++) begin : g_src
         wire [2:0] src = tctl_r[t][TC_SRC_LSB +: 3];
         wire [2:0] pre = tctl_r[t][TC_PRE_LSB +: 3];
         // divide by 8^pre; pre 0 means every clock, codes above 4 saturate at 4096
         wire [11:0] pre_mask = 12'((13'h0001 << (3 * pre)) - 13'h0001);
         wire pre_tick = (pre_r & pre_mask) == pre_mask;
         wire up_tick = upstream_gp_timer_ovf && !up_d_r;
         wire ext_tick = ext_count_in[t] && !ext_d_r[t];
         assign tick[t] = clk_en && tctl_r[t][TC_RUN] && stag_ok &&
            (src == SRC_PRE ? pre_tick : src == SRC_UP ? up_tick : src == SRC_EXT ? ext_tick : 1'b0);
         assign tmr_at_tick[t] = tmr_r[t];
      end
   endgenerate

   // capture on chosen edge, compare on equality at each timer step
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         wire [1:0] edg = cfg_r[c][CF_EDGE_LSB +: 2];
         wire rise = ch_pin_in[c] && !pin_d_r[c];
         wire fall = !ch_pin_in[c] && pin_d_r[c];
         wire t_sel = cfg_r[c][CF_TMR];
         assign cap_ev[c] = clk_en && cfg_r[c][CF_CAP] &&
            ((edg == EDGE_RISE && rise) || (edg == EDGE_FALL && fall) || (edg == EDGE_BOTH && (rise || fall)));
         assign cmp_ev[c] = clk_en && !cfg_r[c][CF_CAP] && (t_sel ? tick[1] : tick[0]) &&
            ch_timer(t_sel, tmr_at_tick[0], tmr_at_tick[1]) == val_r[c];
      end
   endgenerate

   // read data decode, unmapped words read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         IDX_T0_CNT: rd_mux = {16'h0000, tmr_r[0]};
         IDX_T1_CNT: rd_mux = {16'h0000, tmr_r[1]};
         IDX_T0_REL: rd_mux = {16'h0000, rel_r[0]};
         IDX_T1_REL: rd_mux = {16'h0000, rel_r[1]};
         IDX_TCTL: rd_mux = {15'h0000, stag_r, tctl_r[1], tctl_r[0]};
         IDX_CH_SEL: rd_mux = {28'h0000000, sel_r};
         IDX_CH_CFG: rd_mux = {25'h0000000, cfg_r[sel_r]};
         IDX_CH_VAL: rd_mux = {16'h0000, val_r[sel_r]};
         IDX_IRQ: rd_mux = {16'h0000, irq_r};
         IDX_PINS: rd_mux = {ch_pin_in, pin_out_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // bus handshake: waitrequest falls one cycle after the request
   always_ff @(posedge clk) begin
      if (!resetn) begin
         bst_r <= bus_idle_t_s;
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if (clk_en) begin
         if (rd_acc || (avs_write && bst_r == bus_idle_t_s)) begin
            bst_r <= bus_ack_s;
            wait_r <= 1'b0;
            rdata_r <= rd_mux;
         end else begin
            bst_r <= bus_idle_t_s;
            wait_r <= 1'b1;
         end
      end
   end

   // prescaler, stagger phase and edge history
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pre_r <= 12'h000;
         stag_cnt_r <= 3'h0;
         up_d_r <= 1'b0;
         ext_d_r <= '{1'b0, 1'b0};
         pin_d_r <= 16'h0000;
      end else if (clk_en) begin
         pre_r <= pre_r + 12'h001;
         stag_cnt_r <= stag_cnt_r + 3'h1;
         up_d_r <= upstream_gp_timer_ovf;
         ext_d_r <= '{ext_count_in[0], ext_count_in[1]}; // element 0 is listed first
         pin_d_r <= ch_pin_in;
      end
   end

   // timers with reload on overflow
   generate
      for (genvar t = 0; t < 2; t++) begin : g_tmr
         always_ff @(posedge clk) begin
            if (!resetn) begin
               tmr_r[t] <= TIMER_RST;
               rel_r[t] <= TIMER_RST;
               tctl_r[t] <= 8'h00;
            end else if (clk_en) begin
               if (wr_acc && avs_address == AW'(IDX_T0_CNT + t))
                  tmr_r[t] <= avs_writedata[TW-1:0];
               else if (tick[t])
                  tmr_r[t] <= &tmr_r[t] ? rel_r[t] : tmr_r[t] + 16'h0001;
               if (wr_acc && avs_address == AW'(IDX_T0_REL + t))
                  rel_r[t] <= avs_writedata[TW-1:0];
               if (wr_acc && avs_address == IDX_TCTL)
                  tctl_r[t] <= avs_writedata[8*t +: 8];
            end
         end
      end
   endgenerate

   // channel registers: captures win over software writes
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_reg
         always_ff @(posedge clk) begin
            if (!resetn) begin
               cfg_r[c] <= CFG_RST;
               val_r[c] <= TIMER_RST;
            end else if (clk_en) begin
               if (wr_acc && avs_address == IDX_CH_CFG && sel_r == AW'(c))
                  cfg_r[c] <= avs_writedata[6:0];
               if (cap_ev[c])
                  val_r[c] <= ch_timer(cfg_r[c][CF_TMR], tmr_r[0], tmr_r[1]);
               else if (wr_acc && avs_address == IDX_CH_VAL && sel_r == AW'(c))
                  val_r[c] <= avs_writedata[TW-1:0];
            end
         end
      end
   endgenerate

   // channel select, stagger enable
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sel_r <= 4'h0;
         stag_r <= 1'b0;
      end else if (wr_acc) begin
         if (avs_address == IDX_CH_SEL)
            sel_r <= avs_writedata[AW-1:0];
         if (avs_address == IDX_TCTL)
            stag_r <= avs_writedata[TC_STAG];
      end
   end

   // interrupts set by events, cleared by writing one; set wins
   wire [NUM_CH-1:0] irq_clr = (wr_acc && avs_address == IDX_IRQ) ? avs_writedata[NUM_CH-1:0] : 16'h0000;
   // mode 1 toggles; other modes leave the pin alone
   logic [NUM_CH-1:0] tog;
   always_comb begin
      tog = 16'h0000;
      for (int c = 0; c < NUM_CH; c++)
         tog[c] = cmp_ev[c] && cfg_r[c][CF_MODE_LSB +: 3] == MODE_TOGGLE;
   end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_r <= 16'h0000;
         pin_out_r <= 16'h0000;
      end else if (clk_en) begin
         irq_r <= (irq_r & ~irq_clr) | cap_ev | cmp_ev;
         pin_out_r <= pin_out_r ^ tog;
      end
   end

   // output enable low for compare channels, pin driven by the unit
   logic [NUM_CH-1:0] oe_n_r;
   always_ff @(posedge clk) begin
      if (!resetn)
         oe_n_r <= 16'hFFFF;
      else if (clk_en)
         for (int c = 0; c < NUM_CH; c++)
            oe_n_r[c] <= cfg_r[c][CF_CAP];
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign ch_pin_out = pin_out_r;
   assign ch_pin_oe_n = oe_n_r;
   assign ch_irq = irq_r;

   // capture side, watched on channel 3 which the tests drive from outside
   a_capture_value: assert property (@(posedge clk) disable iff (!resetn)
      cap_ev[3] |=> val_r[3] == $past(ch_timer(cfg_r[3][CF_TMR], tmr_r[0], tmr_r[1])))
      else $error("capture value wrong");
   a_capture_irq: assert property (@(posedge clk) disable iff (!resetn)
      cap_ev[3] |=> irq_r[3])
      else $error("capture irq missing");
   a_rising_only: assert property (@(posedge clk) disable iff (!resetn)
      cap_ev[3] && cfg_r[3][CF_EDGE_LSB +: 2] == EDGE_RISE |-> ch_pin_in[3] && !pin_d_r[3])
      else $error("wrong edge captured");
   a_falling_only: assert property (@(posedge clk) disable iff (!resetn)
      cap_ev[3] && cfg_r[3][CF_EDGE_LSB +: 2] == EDGE_FALL |-> !ch_pin_in[3] && pin_d_r[3])
      else $error("rising edge captured");
   a_oe_capture: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && cfg_r[3][CF_CAP] |=> ch_pin_oe_n[3])
      else $error("capture pin driven");

   // compare side, channels 8 to 12 run modes 0 to 4 on timer 0
   a_compare_equal: assert property (@(posedge clk) disable iff (!resetn)
      cmp_ev[8] && !cfg_r[8][CF_TMR] |-> tmr_r[0] == val_r[8])
      else $error("compare without match");
   a_compare_irq: assert property (@(posedge clk) disable iff (!resetn)
      cmp_ev[8] |=> irq_r[8])
      else $error("compare irq missing");
   a_mode0_pin: assert property (@(posedge clk) disable iff (!resetn)
      cmp_ev[8] && cfg_r[8][CF_MODE_LSB +: 3] == MODE_IRQ |=> $stable(pin_out_r[8]))
      else $error("mode 0 moved pin");
   a_toggle_pin: assert property (@(posedge clk) disable iff (!resetn)
      tog[9] |=> pin_out_r[9] != $past(pin_out_r[9]))
      else $error("pin not toggled");
   a_spare_mode_pin: assert property (@(posedge clk) disable iff (!resetn)
      cmp_ev[10] && cfg_r[10][CF_MODE_LSB +: 3] > MODE_TOGGLE |=> $stable(pin_out_r[10]))
      else $error("spare mode moved pin");
   a_oe_compare: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && !cfg_r[9][CF_CAP] |=> !ch_pin_oe_n[9])
      else $error("compare pin not driven");

   // interrupt flags stick until software writes a one
   a_irq_sticky: assert property (@(posedge clk) disable iff (!resetn)
      irq_r[8] && !irq_clr[8] |=> irq_r[8])
      else $error("irq dropped");
   a_irq_clear: assert property (@(posedge clk) disable iff (!resetn)
      irq_clr[8] && !cap_ev[8] && !cmp_ev[8] |=> !irq_r[8])
      else $error("irq clear lost");

   // time bases: one step per tick, frozen with the enable, one tick per count edge
   a_timer_step: assert property (@(posedge clk) disable iff (!resetn)
      tick[0] && !(&tmr_r[0]) && !(wr_acc && avs_address == IDX_T0_CNT) |=> tmr_r[0] == $past(tmr_r[0]) + 16'h0001)
      else $error("timer step wrong");
   a_reload_ovf: assert property (@(posedge clk) disable iff (!resetn)
      tick[0] && &tmr_r[0] && !wr_acc |=> tmr_r[0] == $past(rel_r[0]))
      else $error("reload missed");
   a_timer_freeze: assert property (@(posedge clk) disable iff (!resetn)
      !clk_en |=> $stable(tmr_r[0]) && $stable(tmr_r[1]))
      else $error("timer moved while frozen");
   a_ext_single: assert property (@(posedge clk) disable iff (!resetn)
      tick[0] && tctl_r[0][TC_SRC_LSB +: 3] == SRC_EXT |=> !(tick[0] && tctl_r[0][TC_SRC_LSB +: 3] == SRC_EXT))
      else $error("external count repeated");
   a_up_single: assert property (@(posedge clk) disable iff (!resetn)
      tick[1] && tctl_r[1][TC_SRC_LSB +: 3] == SRC_UP |=> !(tick[1] && tctl_r[1][TC_SRC_LSB +: 3] == SRC_UP))
      else $error("overflow count repeated");
   a_stagger_gap: assert property (@(posedge clk) disable iff (!resetn)
      stag_r && clk_en && stag_cnt_r != 3'h7 |-> !tick[0] && !tick[1])
      else $error("stagger tick early");

   // bus handshake: one low cycle of waitrequest per access
   a_bus_answer: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && bst_r == bus_idle_t_s && avs_read |=> !avs_waitrequest)
      else $error("bus answer late");
   a_bus_release: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
endmodule
`default_nettype wire

// ### tb/dtcc_bench.sv
// self-checking bench for the dual time-base capture/compare unit
`timescale 1ns/1ns
`default_nettype none
module dual_timebase_cc_unit_bench import dtcc_pkg::*; ;
   logic clk, resetn, clk_en, avs_read, avs_write, avs_waitrequest, ovf;
   logic [AW-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0] ext;
   logic [NUM_CH-1:0] pin_in, pin_out, oe_n, irq;
   int err_total, checks, cyc;
   dual_timebase_cc_unit dut_u (.clk(clk), .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .upstream_gp_timer_ovf(ovf), .ext_count_in(ext),
      .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe_n(oe_n), .ch_irq(irq));
   pin_model pm_u (.clk(clk), .pin_out(pin_out), .oe_n(oe_n), .pin_in(pin_in), .ovf(ovf), .ext(ext));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one avalon access; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      // ends when waitrequest is sampled low; if it never falls, only the hang guard ends this wait
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // a spare edge so the next request never lands in the release step
      @(posedge clk);
      chk("waitrequest", 32'h00000001, {31'h0, avs_waitrequest});
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   task automatic t_reset;
      repeat (4) @(posedge clk);
      chk("oe_n", 32'h0000FFFF, {16'h0, oe_n});
      chk("irq", 32'h0, {16'h0, irq});
      resetn <= 1'b1;
      @(posedge clk);
      rd(IDX_T0_CNT, {16'h0, TIMER_RST}, "timer0 count");
      rd(IDX_CH_CFG, {25'h0, CFG_RST}, "channel cfg");
      wr(4'hF, 32'hFFFFFFFF);
      rd(4'hF, 32'h0, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_timer;
      // timer0 on external count, timer1 on upstream overflow, both running
      wr(IDX_TCTL, 32'h000090A0);
      wr(IDX_T0_REL, 32'h00001234);
      wr(IDX_T0_CNT, 32'h0000FFFE);
      repeat (3) pm_u.pulse(0);
      rd(IDX_T0_CNT, 32'h00001235, "timer0 count");
      rd(IDX_T0_REL, 32'h00001234, "timer0 reload");
      wr(IDX_T1_CNT, 32'h0);
      repeat (2) pm_u.pulse(2);
      rd(IDX_T1_CNT, 32'h00000002, "timer1 count");
      $display("test timer done");
   endtask
   task automatic t_compare;
      // modes 0..4 on channels 8..12, all matching 0x0010 of timer0
      for (int m = 0; m < 5; m++) begin
         wr(IDX_CH_SEL, 32'(8 + m));
         wr(IDX_CH_CFG, 32'(m * 2));
         wr(IDX_CH_VAL, 32'h00000010);
      end
      wr(IDX_IRQ, 32'h0000FFFF);
      wr(IDX_T0_CNT, 32'h0000000F);
      repeat (2) pm_u.pulse(0);
      rd(IDX_IRQ, 32'h00001F00, "irq match");
      rd(IDX_PINS, 32'h02000200, "pins toggled");
      chk("oe_n compare", 32'h0, {31'h0, oe_n[9]});
      // second match in the same period
      wr(IDX_IRQ, 32'h0000FFFF);
      wr(IDX_T0_CNT, 32'h00000010);
      pm_u.pulse(0);
      rd(IDX_IRQ, 32'h00001F00, "irq rematch");
      rd(IDX_PINS, 32'h0, "pins toggled back");
      $display("test compare done");
   endtask
   task automatic t_capture;
      // channel 3 captures timer1, still running but given no overflow pulses, each edge choice in turn
      for (int e = 1; e < 4; e++) begin
         wr(IDX_CH_SEL, 32'h3);
         wr(IDX_CH_CFG, 32'(65 + e * 16));
         wr(IDX_T1_CNT, 32'(256 + e));
         wr(IDX_IRQ, 32'h0000FFFF);
         pm_u.set_pin(3, 1'b1);
         repeat (3) @(posedge clk);
         rd(IDX_IRQ, (e != 2) ? 32'h8 : 32'h0, "irq rise");
         wr(IDX_IRQ, 32'h0000FFFF);
         pm_u.set_pin(3, 1'b0);
         repeat (3) @(posedge clk);
         rd(IDX_IRQ, (e != 1) ? 32'h8 : 32'h0, "irq fall");
         rd(IDX_CH_VAL, 32'(256 + e), "captured value");
      end
      chk("oe_n capture", 32'h1, {31'h0, oe_n[3]});
      $display("test capture done");
   endtask
   task automatic t_stagger;
      // timer0 on the plain clock, 80 edges between the two control writes
      wr(IDX_TCTL, 32'h0);
      wr(IDX_T0_CNT, 32'h0);
      wr(IDX_TCTL, 32'h00010080);
      repeat (77) @(posedge clk);
      wr(IDX_TCTL, 32'h0);
      rd(IDX_T0_CNT, 32'(80 / STAGGER_STEP), "stagger count");
      // same window without stagger, 40 of the edges frozen by the enable
      wr(IDX_T0_CNT, 32'h0);
      wr(IDX_TCTL, 32'h00000080);
      clk_en <= 1'b0;
      repeat (40) @(posedge clk);
      clk_en <= 1'b1;
      repeat (37) @(posedge clk);
      wr(IDX_TCTL, 32'h0);
      rd(IDX_T0_CNT, 32'h00000028, "plain count frozen");
      $display("test stagger done");
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         give_verdict;
      end
   end
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      t_reset;
      t_timer;
      t_compare;
      t_capture;
      t_stagger;
      give_verdict;
   end
endmodule
`default_nettype wire

// ### tb/dtcc_pin_model.sv
// far-side model: pin wires, external count inputs and upstream overflow source
`timescale 1ns/1ns
`default_nettype none
module pin_model import dtcc_pkg::*; (
   // clock
   input wire logic clk,
   // unit side of the pins
   input wire logic [NUM_CH-1:0] pin_out,
   input wire logic [NUM_CH-1:0] oe_n,
   output logic [NUM_CH-1:0] pin_in,
   // count sources
   output var logic ovf,
   output var logic [1:0] ext
);
   logic [NUM_CH-1:0] drv_r;
   initial begin
      drv_r = '0;
      ovf = 1'b0;
      ext = 2'h0;
   end
   // wire level: the unit wins where it enables its driver
   assign pin_in = (oe_n & drv_r) | (~oe_n & pin_out);
   // drive one pin level from the outside, changed just after an edge
   task automatic set_pin(input int ch, input logic v);
      @(posedge clk);
      drv_r[ch] <= v;
   endtask
   // one count event: 0/1 external input of that timer, 2 upstream overflow
   task automatic pulse(input int sel);
      @(posedge clk);
      if (sel < 2) begin
         ext[sel] <= 1'b1;
      end else begin
         ovf <= 1'b1;
      end
      repeat (2) @(posedge clk);
      ext <= 2'h0;
      ovf <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule
`default_nettype wire
